/* File: scan_chains.sv */
// Purpose: instruction register and data register chains behind a test port
// Assumes: test clock is its own domain; pads and core run on clk_i
// Notes: pad values cross into the test clock domain through two flops
// Summary of operation
// - a 32-bit identification chain sits between data in and data out
// - identification chain bit zero always reads one
// - identification instruction captures and shifts the fixed identity value
// - bypass chain is one bit and captures zero
// - boundary chain has input, output, enable cells per pad in order
// - boundary chain starts at the pad next to the test port
// - sample/preload captures pad values at capture state rising edge
// - new preload data shifts in while captured data shifts out
// - external test drives pads, internal test drives core inputs
// - access-port access chain is 35 bits long
// - debug-port access chain is 35 bits long
// - abort chain is 35 bits long
// - instruction codes select chains; unknown codes act as bypass
// - identification instruction loads on reset or test-logic-reset
// - update state copies boundary shift stages into holding registers
// - system reset cell is observe only, never driven into the core
`timescale 1ns/100ps
`include "scan_chain_params.svh"
module scan_chains #(
   parameter int NPADS = 8
) (
   input wire logic clk_i, // system clock
   input wire logic arst_n_i, // power-on reset, active low
   input wire logic tck_i, // test clock
   input wire logic trst_n_i, // test reset, active low
   input wire logic tms_i, // test mode select
   input wire logic tdi_i, // test data in
   output logic tdo_o, // test data out
   output logic tdo_oe_n_o, // test data out enable, low drives
   input wire logic [NPADS-1:0] pad_in_i, // pad input levels
   input wire logic [NPADS-1:0] core_out_i, // core output values
   input wire logic [NPADS-1:0] core_oe_i, // core output enables
   input wire logic sys_rst_n_i, // system reset pin level
   output logic [NPADS-1:0] pad_out_o, // value driven on pads
   output logic [NPADS-1:0] pad_oe_o, // pad output enables
   output logic [NPADS-1:0] core_in_o, // value seen by core
   output logic core_rst_n_o, // system reset into core
   output logic [`DBG_W-1:0] debug_port_access_chain_o, // debug-port access update word
   output logic [`DBG_W-1:0] access_port_access_chain_o, // access-port access update word
   output logic [`DBG_W-1:0] abort_data_o // abort update word
);
   localparam int BSW = 3 * NPADS + 1;
   wire logic rst_n = arst_n_i & trst_n_i;

   // pad sampling in clk_i domain, then two flops in tck domain
   logic [BSW-1:0] pad_vec_reg, pad_vec_next;
   logic [BSW-1:0] sync1_reg, sync2_reg;
   logic [NPADS-1:0] pin_s1_reg, pin_s2_reg;
   always_comb begin
      pad_vec_next[0] = sys_rst_n_i;
      for (int p = 0; p < NPADS; p++) begin
         pad_vec_next[3*p+1] = pin_s2_reg[p];
         pad_vec_next[3*p+2] = core_out_i[p];
         pad_vec_next[3*p+3] = core_oe_i[p];
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pad_vec_reg <= '0;
      end else begin
         pin_s1_reg <= pad_in_i;
         pin_s2_reg <= pin_s1_reg;
         pad_vec_reg <= pad_vec_next;
      end
   end
   always_ff @(posedge tck_i or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= pad_vec_reg;
         sync2_reg <= sync1_reg;
      end
   end

   // controller state
   scan_chain_pkg::tap_state_t st_reg, st_next;
   always_comb begin
      case (st_reg)
         scan_chain_pkg::TLR: st_next = tms_i ? scan_chain_pkg::TLR : scan_chain_pkg::RTI;
         scan_chain_pkg::RTI: st_next = tms_i ? scan_chain_pkg::SEL_DR : scan_chain_pkg::RTI;
         scan_chain_pkg::SEL_DR: st_next = tms_i ? scan_chain_pkg::SEL_IR : scan_chain_pkg::CAP_DR;
         scan_chain_pkg::CAP_DR: st_next = tms_i ? scan_chain_pkg::EX1_DR : scan_chain_pkg::SH_DR;
         scan_chain_pkg::SH_DR: st_next = tms_i ? scan_chain_pkg::EX1_DR : scan_chain_pkg::SH_DR;
         scan_chain_pkg::EX1_DR: st_next = tms_i ? scan_chain_pkg::UPD_DR : scan_chain_pkg::PA_DR;
         scan_chain_pkg::PA_DR: st_next = tms_i ? scan_chain_pkg::EX2_DR : scan_chain_pkg::PA_DR;
         scan_chain_pkg::EX2_DR: st_next = tms_i ? scan_chain_pkg::UPD_DR : scan_chain_pkg::SH_DR;
         scan_chain_pkg::UPD_DR: st_next = tms_i ? scan_chain_pkg::SEL_DR : scan_chain_pkg::RTI;
         scan_chain_pkg::SEL_IR: st_next = tms_i ? scan_chain_pkg::TLR : scan_chain_pkg::CAP_IR;
         scan_chain_pkg::CAP_IR: st_next = tms_i ? scan_chain_pkg::EX1_IR : scan_chain_pkg::SH_IR;
         scan_chain_pkg::SH_IR: st_next = tms_i ? scan_chain_pkg::EX1_IR : scan_chain_pkg::SH_IR;
         scan_chain_pkg::EX1_IR: st_next = tms_i ? scan_chain_pkg::UPD_IR : scan_chain_pkg::PA_IR;
         scan_chain_pkg::PA_IR: st_next = tms_i ? scan_chain_pkg::EX2_IR : scan_chain_pkg::PA_IR;
         scan_chain_pkg::EX2_IR: st_next = tms_i ? scan_chain_pkg::UPD_IR : scan_chain_pkg::SH_IR;
         scan_chain_pkg::UPD_IR: st_next = tms_i ? scan_chain_pkg::SEL_DR : scan_chain_pkg::RTI;
         default: st_next = scan_chain_pkg::TLR;
      endcase
   end

   // instruction register
   logic [`IR_W-1:0] ir_reg, ir_next, irsh_reg, irsh_next;
   always_comb begin
      ir_next = ir_reg;
      irsh_next = irsh_reg;
      if (st_reg == scan_chain_pkg::TLR) begin
         ir_next = `IR_IDENT;
      end else if (st_reg == scan_chain_pkg::CAP_IR) begin
         irsh_next = `IR_CAPTURE;
      end else if (st_reg == scan_chain_pkg::SH_IR) begin
         irsh_next = {tdi_i, irsh_reg[`IR_W-1:1]};
      end else if (st_reg == scan_chain_pkg::UPD_IR) begin
         ir_next = irsh_reg;
      end
   end

   typedef enum logic [2:0] {SEL_BYP, SEL_ID, SEL_BS, SEL_AB, SEL_DP, SEL_AP} chain_sel_t;
   chain_sel_t sel;
   always_comb begin
      case (ir_reg)
         `IR_EXTEST, `IR_INTEST, `IR_SAMPLE: sel = SEL_BS;
         `IR_ABORT: sel = SEL_AB;
         `IR_DEBUG_PORT_ACCESS: sel = SEL_DP;
         `IR_ACCESS_PORT_ACCESS: sel = SEL_AP;
         `IR_IDENT: sel = SEL_ID;
         default: sel = SEL_BYP;
      endcase
   end

   // data register chains
   logic [`ID_W-1:0] id_reg, id_next;
   logic byp_reg, byp_next;
   logic [BSW-1:0] bs_reg, bs_next, bshold_reg, bshold_next;
   logic [`DBG_W-1:0] ab_reg, ab_next, dp_reg, dp_next, ap_reg, ap_next;
   logic [`DBG_W-1:0] abu_reg, abu_next, dpu_reg, dpu_next, apu_reg, apu_next;
   logic upd_tgl_reg, upd_tgl_next;
   wire logic cap = (st_reg == scan_chain_pkg::CAP_DR);
   wire logic shf = (st_reg == scan_chain_pkg::SH_DR);
   wire logic upd = (st_reg == scan_chain_pkg::UPD_DR);

   function automatic logic [`DBG_W-1:0] dbg_step(input logic [`DBG_W-1:0] v, input logic d);
      dbg_step = {d, v[`DBG_W-1:1]};
   endfunction : dbg_step

   always_comb begin
      id_next = id_reg;
      byp_next = byp_reg;
      bs_next = bs_reg;
      ab_next = ab_reg;
      dp_next = dp_reg;
      ap_next = ap_reg;
      bshold_next = bshold_reg;
      abu_next = abu_reg;
      dpu_next = dpu_reg;
      apu_next = apu_reg;
      upd_tgl_next = upd_tgl_reg ^ (upd && sel == SEL_BS);
      if (cap) begin
         case (sel)
            SEL_ID: id_next = `ID_VALUE;
            SEL_BYP: byp_next = `BYP_CAPTURE;
            SEL_BS: bs_next = sync2_reg;
            SEL_AB: ab_next = abu_reg;
            SEL_DP: dp_next = dpu_reg;
            SEL_AP: ap_next = apu_reg;
            default: byp_next = `BYP_CAPTURE;
         endcase
      end else if (shf) begin
         case (sel)
            SEL_ID: id_next = {tdi_i, id_reg[`ID_W-1:1]};
            SEL_BYP: byp_next = tdi_i;
            SEL_BS: bs_next = {tdi_i, bs_reg[BSW-1:1]};
            SEL_AB: ab_next = dbg_step(ab_reg, tdi_i);
            SEL_DP: dp_next = dbg_step(dp_reg, tdi_i);
            SEL_AP: ap_next = dbg_step(ap_reg, tdi_i);
            default: byp_next = tdi_i;
         endcase
      end else if (upd) begin
         case (sel)
            SEL_BS: bshold_next = bs_reg;
            SEL_AB: abu_next = ab_reg;
            SEL_DP: dpu_next = dp_reg;
            SEL_AP: apu_next = ap_reg;
            default: byp_next = byp_reg;
         endcase
      end
   end

   logic tdo_reg, tdo_next, oe_n_reg, oe_n_next;
   always_comb begin
      case (st_reg == scan_chain_pkg::SH_IR ? SEL_BYP : sel)
         SEL_ID: tdo_next = id_reg[0];
         SEL_BS: tdo_next = bs_reg[0];
         SEL_AB: tdo_next = ab_reg[0];
         SEL_DP: tdo_next = dp_reg[0];
         SEL_AP: tdo_next = ap_reg[0];
         default: tdo_next = byp_reg;
      endcase
      if (st_reg == scan_chain_pkg::SH_IR) begin
         tdo_next = irsh_reg[0];
      end
      oe_n_next = !(shf || st_reg == scan_chain_pkg::SH_IR);
   end

   always_ff @(posedge tck_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= scan_chain_pkg::TLR;
         ir_reg <= `IR_IDENT;
         irsh_reg <= '0;
         id_reg <= '0;
         byp_reg <= 1'b0;
         bs_reg <= '0;
         bshold_reg <= '0;
         ab_reg <= '0;
         dp_reg <= '0;
         ap_reg <= '0;
         abu_reg <= '0;
         dpu_reg <= '0;
         apu_reg <= '0;
         upd_tgl_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         ir_reg <= ir_next;
         irsh_reg <= irsh_next;
         id_reg <= id_next;
         byp_reg <= byp_next;
         bs_reg <= bs_next;
         bshold_reg <= bshold_next;
         ab_reg <= ab_next;
         dp_reg <= dp_next;
         ap_reg <= ap_next;
         abu_reg <= abu_next;
         dpu_reg <= dpu_next;
         apu_reg <= apu_next;
         upd_tgl_reg <= upd_tgl_next;
      end
   end

   // tdo changes on falling test clock edge
   always_ff @(negedge tck_i or negedge rst_n) begin
      if (!rst_n) begin
         tdo_reg <= 1'b0;
         oe_n_reg <= 1'b1;
      end else begin
         tdo_reg <= tdo_next;
         oe_n_reg <= oe_n_next;
      end
   end
   assign tdo_o = tdo_reg;
   assign tdo_oe_n_o = oe_n_reg;
   assign debug_port_access_chain_o = dpu_reg;
   assign access_port_access_chain_o = apu_reg;
   assign abort_data_o = abu_reg;

   // mode bits are independent levels; the held word is taken once its toggle has crossed
   logic [1:0] mode_s1_reg, mode_s2_reg;
   logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
   logic [BSW-1:0] hold_reg, hold_next;
   wire logic [1:0] mode_tck = {ir_reg == `IR_INTEST, ir_reg == `IR_EXTEST};
   logic [NPADS-1:0] pout_reg, pout_next, poe_reg, poe_next, cin_reg, cin_next;
   always_comb begin
      hold_next = (tgl_s2_reg != tgl_s3_reg) ? bshold_reg : hold_reg;
      for (int p = 0; p < NPADS; p++) begin
         cin_next[p] = mode_s2_reg[1] ? hold_reg[3*p+1] : pin_s2_reg[p];
         pout_next[p] = mode_s2_reg[0] ? hold_reg[3*p+2] : core_out_i[p];
         poe_next[p] = mode_s2_reg[0] ? hold_reg[3*p+3] : core_oe_i[p];
      end
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_s1_reg <= '0;
         mode_s2_reg <= '0;
         tgl_s1_reg <= 1'b0;
         tgl_s2_reg <= 1'b0;
         tgl_s3_reg <= 1'b0;
         hold_reg <= '0;
         pout_reg <= '0;
         poe_reg <= '0;
         cin_reg <= '0;
      end else begin
         mode_s1_reg <= mode_tck;
         mode_s2_reg <= mode_s1_reg;
         tgl_s1_reg <= upd_tgl_reg;
         tgl_s2_reg <= tgl_s1_reg;
         tgl_s3_reg <= tgl_s2_reg;
         hold_reg <= hold_next;
         pout_reg <= pout_next;
         poe_reg <= poe_next;
         cin_reg <= cin_next;
      end
   end
   assign pad_out_o = pout_reg;
   assign pad_oe_o = poe_reg;
   assign core_in_o = cin_reg;
   assign core_rst_n_o = sys_rst_n_i;

   sequence cap_id_s;
      cap && sel == SEL_ID;
   endsequence
   id_capture_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      cap_id_s |=> id_reg == `ID_VALUE)
      else $error("identity not captured");
   id_lsb_one_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      cap_id_s |=> id_reg[0] == 1'b1)
      else $error("identity lsb not one");
   bypass_zero_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      cap && sel == SEL_BYP |=> byp_reg == 1'b0)
      else $error("bypass capture not zero");
   tlr_ident_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      st_reg == scan_chain_pkg::TLR |=> ir_reg == `IR_IDENT)
      else $error("identity instruction not loaded");
   bs_update_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      upd && sel == SEL_BS |=> bshold_reg == $past(bs_reg))
      else $error("boundary hold not updated");
   bs_shift_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      shf && sel == SEL_BS |=> bs_reg[BSW-2:0] == $past(bs_reg[BSW-1:1]))
      else $error("boundary shift wrong");
   dp_shift_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      shf && sel == SEL_DP |=> dp_reg[`DBG_W-1] == $past(tdi_i))
      else $error("debug chain shift wrong");
   unknown_bypass_a: assert property (@(posedge tck_i) disable iff (!rst_n)
      !(ir_reg inside {`IR_EXTEST, `IR_INTEST, `IR_SAMPLE, `IR_ABORT, `IR_DEBUG_PORT_ACCESS,
      `IR_ACCESS_PORT_ACCESS, `IR_IDENT}) |-> sel == SEL_BYP)
      else $error("reserved code not bypass");
   extest_drive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      mode_s2_reg[0] |=> pad_out_o[0] == $past(hold_reg[2]))
      else $error("external test not driving pads");
   rst_observe_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      core_rst_n_o == sys_rst_n_i)
      else $error("reset cell drives core");
endmodule : scan_chains

/* File: scan_chain_params.svh */
// Purpose: constants for the test-port data register chains
// Assumes: 4-bit instruction register, 35-bit debug chains
// Notes: identification value is arbitrary
`ifndef SCAN_CHAIN_PARAMS_SVH
`define SCAN_CHAIN_PARAMS_SVH
`define IR_W 4
`define IR_EXTEST 4'h0
`define IR_INTEST 4'h1
`define IR_SAMPLE 4'h2
`define IR_ABORT 4'h8
`define IR_DEBUG_PORT_ACCESS 4'ha
`define IR_ACCESS_PORT_ACCESS 4'hb
`define IR_IDENT 4'he
`define IR_BYPASS 4'hf
`define IR_CAPTURE 4'h1
`define ID_W 32
`define ID_VALUE 32'h1234_5679
`define DBG_W 35
`define BYP_CAPTURE 1'h0
`endif

/* File: scan_chain_pkg.sv */
// Purpose: types for the test-port data register chains
// Assumes: standard sixteen-state test access controller
// Notes: none
package scan_chain_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } tap_state_t;
endpackage : scan_chain_pkg

/* File: jtag_host_model.sv */
// Purpose: behavioural test-port controller that drives the serial lines
// Assumes: test clock stands low between frames, 48 ns period inside them
// Notes: data in toggles whenever it carries no shift bit
`timescale 1ns/100ps
module jtag_host_model (
   output logic tck_o, // test clock
   output logic tms_o, // test mode select
   output logic tdi_o, // test data in
   output logic trst_n_o, // test reset, active low
   input wire logic tdo_i, // test data out
   input wire logic tdo_oe_n_i // test data out enable, low drives
);
   int oe_low = 0;
   initial begin
      tck_o = 1'h0;
      tms_o = 1'h1;
      tdi_o = 1'h0;
      trst_n_o = 1'h1;
   end

   // one test clock period; data out is taken at the rising edge
   task automatic pulse(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #24;
      q = tdo_i;
      if (!tdo_oe_n_i) oe_low++;
      tck_o = 1'h1;
      #24;
      tck_o = 1'h0;
   endtask : pulse

   task automatic goto_reset();
      logic q;
      repeat (5) pulse(1'h1, ~tdi_o, q);
      pulse(1'h0, ~tdi_o, q);
   endtask : goto_reset

   task automatic test_reset();
      logic q;
      trst_n_o = 1'h0;
      #48;
      trst_n_o = 1'h1;
      #24;
      pulse(1'h0, ~tdi_o, q);
   endtask : test_reset

   // starts and ends in run-test/idle
   task automatic scan(input logic ir, input int n, input logic [79:0] din,
                       output logic [79:0] dout);
      logic q;
      dout = '0;
      oe_low = 0;
      pulse(1'h1, ~tdi_o, q);
      if (ir) pulse(1'h1, ~tdi_o, q);
      pulse(1'h0, ~tdi_o, q);
      pulse(1'h0, ~tdi_o, q);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], q);
         dout[i] = q;
      end
      pulse(1'h1, ~tdi_o, q);
      pulse(1'h0, ~tdi_o, q);
   endtask : scan
endmodule : jtag_host_model

/* File: tb_jtag_data_register_chains.sv */
// Purpose: self-checking bench for the test-port data register chains
// Assumes: pad effects settle within eight system clocks after an update
// Notes: chain lengths are found from where shifted-in data reappears
`timescale 1ns/100ps
`include "scan_chain_params.svh"
module tb_jtag_data_register_chains;
   localparam int NPADS = 8;
   localparam int BSL = 3 * NPADS + 1;
   logic clk_i = 1'h0;
   logic arst_n_i = 1'h0;
   logic tck, tms, tdi, trst_n, tdo, tdo_oe_n, core_rst_n, sys_rst_n = 1'h1;
   logic [NPADS-1:0] pin = '0, cout = '0, coe = '0, pout, poe, cin, e_o, e_e, e_i;
   logic [`DBG_W-1:0] dp_d, ap_d, ab_d;
   logic [79:0] din, dout, e, pre;
   logic [3:0] codes [10] = '{`IR_EXTEST, `IR_INTEST, `IR_SAMPLE, `IR_ABORT,
      `IR_DEBUG_PORT_ACCESS, `IR_ACCESS_PORT_ACCESS, `IR_IDENT, `IR_BYPASS, 4'h3, 4'h7};
   int failures = 0;
   int total_checks = 0;
   int len, k;
   bit ok;

   scan_chains #(.NPADS(NPADS)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .tck_i(tck),
      .trst_n_i(trst_n), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
      .pad_in_i(pin), .core_out_i(cout), .core_oe_i(coe), .sys_rst_n_i(sys_rst_n),
      .pad_out_o(pout), .pad_oe_o(poe), .core_in_o(cin), .core_rst_n_o(core_rst_n),
      .debug_port_access_chain_o(dp_d), .access_port_access_chain_o(ap_d),
      .abort_data_o(ab_d));
   jtag_host_model host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
      .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n));

   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   function automatic int exp_len(input logic [3:0] c);
      case (c)
         `IR_EXTEST, `IR_INTEST, `IR_SAMPLE: return BSL;
         `IR_ABORT, `IR_DEBUG_PORT_ACCESS, `IR_ACCESS_PORT_ACCESS: return `DBG_W;
         `IR_IDENT: return `ID_W;
         default: return 1;
      endcase
   endfunction : exp_len

   task automatic set_ir(input logic [3:0] c);
      din = {76'h0, c};
      host.scan(1'h1, 4, din, dout);
      repeat (8) @(negedge clk_i);
   endtask : set_ir

   task automatic rnd();
      din = {16'h0, 32'($urandom), 32'($urandom)};
   endtask : rnd

   initial begin
      #5_000_000;
      failures++;
      wrap_up();
   end

   initial begin
      k = $urandom(58);
      repeat (4) @(posedge clk_i);
      @(negedge clk_i) arst_n_i = 1'h1;
      host.goto_reset();
      host.scan(1'h0, 32, 80'h0, dout);
      check(dout[31:0], `ID_VALUE);
      check(dout[0], 1'h1);
      check(80'(host.oe_low), 80'(`ID_W));
      check(tdo_oe_n, 1'h1);
      foreach (codes[c]) begin
         set_ir(codes[c]);
         rnd();
         host.scan(1'h0, 72, din, dout);
         len = 0;
         for (int l = 40; l >= 1; l--) begin
            ok = 1;
            for (k = l; k < 72; k++) if (dout[k] !== din[k-l]) ok = 0;
            if (ok) len = l;
         end
         check(80'(len), 80'(exp_len(codes[c])));
         if (codes[c] == `IR_IDENT) check(dout[31:0], `ID_VALUE);
         if (exp_len(codes[c]) == 1) check(dout[0], `BYP_CAPTURE);
         if (codes[c] == `IR_ABORT) check(ab_d, din[71-:35]);
         if (codes[c] == `IR_DEBUG_PORT_ACCESS) check(dp_d, din[71-:35]);
         if (codes[c] == `IR_ACCESS_PORT_ACCESS) check(ap_d, din[71-:35]);
      end
      set_ir(`IR_SAMPLE);
      @(negedge clk_i);
      pin = NPADS'($urandom);
      cout = NPADS'($urandom);
      coe = NPADS'($urandom);
      sys_rst_n = 1'h0;
      repeat (8) @(negedge clk_i);
      rnd();
      pre = din;
      host.scan(1'h0, BSL, din, dout);
      e = '0;
      e[0] = sys_rst_n;
      for (int p = 0; p < NPADS; p++) begin
         e[3*p+1] = pin[p];
         e[3*p+2] = cout[p];
         e[3*p+3] = coe[p];
         e_i[p] = pre[3*p+1];
         e_o[p] = pre[3*p+2];
         e_e[p] = pre[3*p+3];
      end
      check(dout[BSL-1:0], e[BSL-1:0]);
      check(pout, cout);
      set_ir(`IR_EXTEST);
      check(pout, e_o);
      check(poe, e_e);
      check(cin, pin);
      set_ir(`IR_INTEST);
      check(cin, e_i);
      check(pout, cout);
      check(core_rst_n, sys_rst_n);
      @(negedge clk_i) sys_rst_n = 1'h1;
      @(negedge clk_i);
      check(core_rst_n, 1'h1);
      set_ir(`IR_BYPASS);
      host.test_reset();
      host.scan(1'h0, 32, 80'h0, dout);
      check(dout[31:0], `ID_VALUE);
      wrap_up();
   end
endmodule : tb_jtag_data_register_chains
